// [dv/osc_ctl_properties.sv]
/* Assertions on the ports of the clock control block.
   Assumes one clock domain and the register map of osc_ctl_pkg. */
`timescale 1ns/10ps
`default_nettype none
module osc_ctl_properties #(
    parameter int PLL_LOCK_CYCLES = 40
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic [osc_ctl_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [osc_ctl_pkg::DATA_W-1:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    input wire logic [osc_ctl_pkg::DATA_W-1:0] reg_rdata,
    input wire logic pll_mode_config,
    input wire logic watchdog_enable,
    input wire logic clock_monitor_enable,
    input wire logic primary_osc_ready,
    input wire logic primary_clk_tick,
    input wire logic primary_osc_enable,
    input wire logic pll_power_on,
    input wire logic slow_osc_running,
    input wire logic device_clk_en,
    input wire osc_ctl_pkg::src_e active_source
);
    logic [1:0] css_sh;
    logic pll_sh;
    int pll_cnt;
    wire css_wr = reg_write && reg_addr == osc_ctl_pkg::OSC_CONTROL_ADDR;
    wire tune_wr = reg_write && reg_addr == osc_ctl_pkg::OSC_TUNING_ADDR;

    // Shadow of the select field and PLL enable bit
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            css_sh <= 2'h0;
            pll_sh <= 1'b0;
        end else begin
            if (css_wr) begin
                css_sh <= reg_wdata[1:0];
            end
            if (tune_wr) begin
                pll_sh <= reg_wdata[osc_ctl_pkg::PLL_EN_BIT];
            end
        end
    end

    // Cycles since the PLL was powered, saturating
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            pll_cnt <= 0;
        end else if (!pll_power_on) begin
            pll_cnt <= 0;
        end else if (pll_cnt <= PLL_LOCK_CYCLES) begin
            pll_cnt <= pll_cnt + 1;
        end
    end

    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);

    a_pll_gate: assert property (
        pll_power_on == (pll_mode_config && pll_sh && css_sh != 2'h3))
        else $error("PLL power disagrees with mode and enable");
    a_slow_alive: assert property (
        (watchdog_enable || clock_monitor_enable) |-> slow_osc_running)
        else $error("slow oscillator stopped while needed");
    a_rdata_idle: assert property (
        !$past(reg_read) |-> reg_rdata == 8'h00)
        else $error("read data outside read slot");
    a_select_kept: assert property (
        ($past(reg_read) && $past(reg_addr) == 4'h1)
        |-> reg_rdata[1:0] == css_sh)
        else $error("select bits changed by switch");
    a_pll_lock_wait: assert property (
        active_source == osc_ctl_pkg::SRC_PLL
        |-> pll_cnt >= PLL_LOCK_CYCLES)
        else $error("PLL taken before lock time");
    a_pll_switch_bound: assert property (
        (pll_cnt == PLL_LOCK_CYCLES && primary_osc_ready)
        |-> ##[1:40] active_source == osc_ctl_pkg::SRC_PLL)
        else $error("no automatic switch to PLL");
    a_primary_off: assert property (
        (css_sh == 2'h3 && $changed(active_source)) |-> !primary_osc_enable)
        else $error("primary left running in internal mode");
    a_primary_ready_first: assert property (
        (active_source == osc_ctl_pkg::SRC_PRIMARY
         && $past(active_source) != osc_ctl_pkg::SRC_PRIMARY)
        |-> $past(primary_osc_ready))
        else $error("switched to primary before ready");
    a_primary_restart: assert property (
        css_sh != 2'h3 |=> primary_osc_enable)
        else $error("primary not started outside internal mode");
    a_primary_ticks: assert property (
        (active_source == osc_ctl_pkg::SRC_PRIMARY && device_clk_en)
        |-> primary_clk_tick)
        else $error("stray device clock pulse on primary");
    a_switch_muted: assert property (
        $changed(active_source) |-> !$past(device_clk_en))
        else $error("device clock pulse at source change");
endmodule // osc_ctl_properties

bind osc_clock_ctl osc_ctl_properties #(
    .PLL_LOCK_CYCLES(PLL_LOCK_CYCLES)
) i_props (.clk, .resetn, .reg_addr, .reg_wdata, .reg_write, .reg_read,
    .reg_rdata, .pll_mode_config, .watchdog_enable, .clock_monitor_enable,
    .primary_osc_ready, .primary_clk_tick, .primary_osc_enable,
    .pll_power_on, .slow_osc_running, .device_clk_en, .active_source);
`default_nettype wire

// [dv/prim_osc_model.sv]
/* Primary oscillator model: start-up delay, then ticks every DIV cycles.
   Assumes enable comes from the block, synchronous to clk. */
`timescale 1ns/10ps
`default_nettype none
module prim_osc_model #(
    parameter int START_CYC = 50,
    parameter int DIV = 4
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic enable,
    output logic ready,
    output logic tick
);
    int cnt;

    // Run time since enable, cleared when stopped
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            cnt <= 0;
        end else if (!enable) begin
            cnt <= 0;
        end else begin
            cnt <= cnt + 1;
        end
    end

    assign ready = enable && cnt >= START_CYC;
    assign tick = ready && cnt % DIV == 0;
endmodule // prim_osc_model
`default_nettype wire

// [dv/tb_internal_osc_tune_and_internal_clock_run_mode.sv]
/* Self-checking bench for the clock control block.
   Assumes the primary oscillator model and the bound checker. */
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin failures++; \
    $display("BAD %0t got %h exp %h", $time, a, e); end end
module tb_internal_osc_tune_and_internal_clock_run_mode;
    typedef struct {
        logic [7:0] tune;
        logic [7:0] ctrl;
        logic [7:0] rd;
        osc_ctl_pkg::src_e src;
    } row_s;
    row_s rows [4] = '{
        '{8'h00, 8'h83, 8'h83, osc_ctl_pkg::SRC_FAST},
        '{8'h80, 8'h87, 8'h87, osc_ctl_pkg::SRC_FAST_LOW},
        '{8'h00, 8'h07, 8'h07, osc_ctl_pkg::SRC_SLOW},
        '{8'h00, 8'h80, 8'h88, osc_ctl_pkg::SRC_PRIMARY}};
    logic clk, resetn, reg_write, reg_read, pll_mode_config;
    logic watchdog_enable, clock_monitor_enable;
    logic [3:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata, d;
    logic ready, tick, osc_en, pll_on, slow_on, dev_en;
    osc_ctl_pkg::src_e active_source;
    int failures = 0;
    int checks = 0;
    int n;
    longint inc, expn;

    // Design and primary oscillator
    osc_clock_ctl #(.FAST_SETTLE_CYCLES(20), .PLL_LOCK_CYCLES(40)) i_dut (
        .clk(clk), .resetn(resetn), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
        .reg_rdata(reg_rdata), .pll_mode_config(pll_mode_config),
        .watchdog_enable(watchdog_enable),
        .clock_monitor_enable(clock_monitor_enable),
        .primary_osc_ready(ready), .primary_clk_tick(tick),
        .primary_osc_enable(osc_en), .pll_power_on(pll_on),
        .slow_osc_running(slow_on), .device_clk_en(dev_en),
        .active_source(active_source));
    prim_osc_model i_prim (.clk(clk), .resetn(resetn), .enable(osc_en),
        .ready(ready), .tick(tick));

    // Clock
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    task automatic end_sim;
        if (failures == 0 && checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] v);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= v;
        reg_write <= 1'b1;
        @(posedge clk);
        reg_write <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] a, output logic [7:0] v);
        @(posedge clk);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge clk);
        reg_read <= 1'b0;
        #1;
        v = reg_rdata;
    endtask

    task automatic wait_src(input osc_ctl_pkg::src_e s);
        n = 0;
        while (active_source !== s && n < 6000) begin
            @(posedge clk);
            #1;
            n++;
        end
        `CHK(active_source, s)
    endtask

    // Reset, with the values held during it
    task automatic do_reset;
        @(posedge clk);
        resetn <= 1'b0;
        repeat (3) @(posedge clk);
        #1;
        `CHK(active_source, osc_ctl_pkg::SRC_FAST)
        `CHK(osc_en, 1'b1)
        `CHK(dev_en, 1'b0)
        @(posedge clk);
        resetn <= 1'b1;
        rd(4'h0, d);
        `CHK(d, 8'h00)
        wait_src(osc_ctl_pkg::SRC_PRIMARY);
        rd(4'h1, d);
        `CHK(d, 8'h08)
    endtask

    // Fast oscillator pulses over 2048 cycles against the tuning value
    task automatic count_fast(input logic [7:0] t);
        wr(4'h0, t);
        rd(4'h1, d);
        `CHK(d, 8'h03)
        repeat (30) @(posedge clk);
        inc = longint'(osc_ctl_pkg::FAST_INC_NOM) + longint'($signed(t[5:0]))
            * longint'(osc_ctl_pkg::FAST_INC_STEP);
        expn = (2048 * inc) >>> 24;
        n = 0;
        repeat (2048) begin
            @(posedge clk);
            #1;
            if (dev_en === 1'b1) n++;
        end
        `CHK(n >= expn && n <= expn + 1, 1'b1)
    endtask

    // Watchdog against a hang
    initial begin
        #1_800_000;
        failures++;
        end_sim();
    end

    // Main sequence
    initial begin
        resetn = 1'b0;
        reg_write = 1'b0;
        reg_read = 1'b0;
        reg_addr = 4'h0;
        reg_wdata = 8'h00;
        pll_mode_config = 1'b0;
        watchdog_enable = 1'b0;
        clock_monitor_enable = 1'b0;
        do_reset();
        rd(4'h5, d);
        `CHK(d, 8'h00)
        for (int i = 0; i < 4; i++) begin
            watchdog_enable <= i[0];
            clock_monitor_enable <= i[1];
            wr(4'h0, rows[i].tune);
            wr(4'h1, rows[i].ctrl);
            wait_src(rows[i].src);
            `CHK(active_source, rows[i].src)
            rd(4'h1, d);
            `CHK(d, rows[i].rd)
            `CHK(slow_on, i[0] | i[1])
        end
        wr(4'h1, 8'h03);
        wait_src(osc_ctl_pkg::SRC_FAST);
        count_fast(8'h00);
        count_fast(8'h1f);
        count_fast(8'h20);
        wr(4'h1, 8'hff);
        rd(4'h1, d);
        `CHK(d, 8'h87)
        wr(4'h1, 8'h00);
        wait_src(osc_ctl_pkg::SRC_PRIMARY);
        do_reset();
        wr(4'h0, 8'h40);
        repeat (2) @(posedge clk);
        `CHK(pll_on, 1'b0)
        pll_mode_config <= 1'b1;
        @(posedge clk);
        #1;
        `CHK(pll_on, 1'b1)
        wait_src(osc_ctl_pkg::SRC_PLL);
        `CHK(n >= 40, 1'b1)
        `CHK(active_source, osc_ctl_pkg::SRC_PLL)
        @(posedge clk);
        #1;
        `CHK(dev_en, 1'b1)
        end_sim();
    end
endmodule // tb_internal_osc_tune_and_internal_clock_run_mode
`default_nettype wire

// [include/osc_ctl_pkg.sv]
/*
 * Constants, register layout and source encoding for the internal
 * oscillator tuning and clock switching block.
 * Assumes a single 50 MHz system clock; every oscillator is modelled
 * as a one-cycle enable pulse derived from that clock.
 */
package osc_ctl_pkg;

    // System clock and oscillator rates
    localparam longint CLK_HZ = 50_000_000;
    localparam longint FAST_OSC_HZ = 8_000_000;
    localparam longint SLOW_OSC_HZ = 31_000;

    // Phase accumulators for the oscillator models
    localparam int ACC_W = 24;
    localparam logic [ACC_W-1:0] FAST_INC_NOM =
        ACC_W'((FAST_OSC_HZ << ACC_W) / CLK_HZ);
    localparam logic [ACC_W-1:0] FAST_INC_STEP = FAST_INC_NOM >> 7;
    localparam logic [ACC_W-1:0] SLOW_INC =
        ACC_W'((SLOW_OSC_HZ << ACC_W) / CLK_HZ);
    localparam int LOW_DIV_W = 8;

    // Settle and lock times, then their cycle counts (rounded down)
    localparam longint FAST_SETTLE_MS = 1;
    localparam longint PLL_LOCK_MS = 2;
    localparam int FAST_SETTLE_CYCLES = int'(FAST_SETTLE_MS * CLK_HZ / 1000);
    localparam int PLL_LOCK_CYCLES = int'(PLL_LOCK_MS * CLK_HZ / 1000);
    localparam int TMR_W = 17;

    // Register port
    localparam int ADDR_W = 4;
    localparam int DATA_W = 8;
    localparam logic [ADDR_W-1:0] OSC_TUNING_ADDR = 4'h0;
    localparam logic [ADDR_W-1:0] OSC_CONTROL_ADDR = 4'h1;

    // Tuning register fields
    localparam int TUNE_LSB = 0;
    localparam int TUNE_W = 6;
    localparam int PLL_EN_BIT = 6;
    localparam int LF_SRC_BIT = 7;
    localparam logic [DATA_W-1:0] OSC_TUNING_RESET = 8'h00;

    // Control register fields
    localparam int CSS_LSB = 0;
    localparam int LOW_FREQ_BIT = 2;
    localparam int STARTUP_BIT = 3;
    localparam int IDLE_BIT = 7;
    localparam logic [1:0] CSS_RESET = 2'h0;
    localparam logic [1:0] CSS_INTERNAL = 2'h3;

    // Device clock sources
    typedef enum logic [2:0] {
        SRC_PRIMARY,
        SRC_FAST,
        SRC_FAST_LOW,
        SRC_SLOW,
        SRC_PLL
    } src_e;

endpackage

// [include/tick_if.sv]
/*
 * Carrier between an oscillator model and its user: phase increment,
 * run enable and the resulting tick.
 * Assumes the same clock on both sides.
 */
`timescale 1ns/10ps
`default_nettype none

interface tick_if #(
    parameter int ACC_W = 24
);
    logic [ACC_W-1:0] inc;
    logic run;
    logic tick;

    modport gen (input inc, input run, output tick);
    modport user (output inc, output run, input tick);
endinterface

`default_nettype wire

// [logic/osc_clock_ctl.sv]
/*
 * Internal oscillator tuning and clock source switching: tuning and
 * control registers, fast and slow internal oscillator models, PLL
 * lock wait, low-frequency source choice, primary start-up handling
 * and a glitch-free device clock selector.
 * Assumes the primary oscillator and its start-up timer sit outside;
 * primary_clk_tick and primary_osc_ready are synchronous to clk.
 * The device clock is delivered as a one-cycle enable pulse.
 */
// Implementation choices: strobed register access and the register addresses.
`timescale 1ns/10ps
`default_nettype none

module osc_clock_ctl #(
    parameter int FAST_SETTLE_CYCLES = osc_ctl_pkg::FAST_SETTLE_CYCLES,
    parameter int PLL_LOCK_CYCLES = osc_ctl_pkg::PLL_LOCK_CYCLES
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic [osc_ctl_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [osc_ctl_pkg::DATA_W-1:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [osc_ctl_pkg::DATA_W-1:0] reg_rdata,
    input wire logic pll_mode_config,
    input wire logic watchdog_enable,
    input wire logic clock_monitor_enable,
    input wire logic primary_osc_ready,
    input wire logic primary_clk_tick,
    output logic primary_osc_enable,
    output logic pll_power_on,
    output logic slow_osc_running,
    output logic device_clk_en,
    output osc_ctl_pkg::src_e active_source
);

    localparam int TW = osc_ctl_pkg::TMR_W;
    localparam int AW = osc_ctl_pkg::ACC_W;

    typedef enum logic [1:0] {
        SW_RUN,
        SW_DRAIN,
        SW_ALIGN
    } sw_state_e;

    // Register state
    logic [osc_ctl_pkg::TUNE_W-1:0] tune_reg;
    logic pll_enable_bit_reg;
    logic low_freq_source_select_reg;
    logic [1:0] clock_source_select_reg;
    logic low_freq_option_reg;
    logic startup_complete_flag_reg;
    logic idle_on_sleep_enable_reg;
    logic [osc_ctl_pkg::DATA_W-1:0] rdata_reg;

    // Oscillator and switching state
    logic [osc_ctl_pkg::TUNE_W-1:0] tune_applied_reg;
    logic [osc_ctl_pkg::LOW_DIV_W-1:0] low_div_reg;
    logic fast_low_tick_reg;
    logic pll_locked_reg;
    logic pll_on_d_reg;
    logic primary_en_reg;
    osc_ctl_pkg::src_e cur_src_reg;
    osc_ctl_pkg::src_e pend_src_reg;
    osc_ctl_pkg::src_e target_src;
    sw_state_e sw_state_reg;
    sw_state_e sw_state_next;

    // Decode wires
    logic wr_tuning;
    logic wr_control;
    logic rd_tuning;
    logic rd_control;
    logic internal_mode;
    logic pll_on;
    logic pll_rise;
    logic fast_settle_done;
    logic pll_lock_done;
    logic [AW-1:0] tune_sx;
    logic [AW-1:0] fast_inc;
    logic cur_tick;
    logic pend_tick;
    logic commit;
    osc_ctl_pkg::src_e base_internal;
    logic [osc_ctl_pkg::DATA_W-1:0] tuning_view;
    logic [osc_ctl_pkg::DATA_W-1:0] control_view;

    tick_if #(.ACC_W(AW)) fast_if ();
    tick_if #(.ACC_W(AW)) slow_if ();

    // Register port decode
    assign wr_tuning = reg_write && (reg_addr == osc_ctl_pkg::OSC_TUNING_ADDR);
    assign wr_control =
        reg_write && (reg_addr == osc_ctl_pkg::OSC_CONTROL_ADDR);
    assign rd_tuning = reg_read && (reg_addr == osc_ctl_pkg::OSC_TUNING_ADDR);
    assign rd_control =
        reg_read && (reg_addr == osc_ctl_pkg::OSC_CONTROL_ADDR);

    // Read views; unused bits read zero
    assign tuning_view = {low_freq_source_select_reg, pll_enable_bit_reg,
                          tune_reg};
    assign control_view = {idle_on_sleep_enable_reg, 3'h0,
                           startup_complete_flag_reg, low_freq_option_reg,
                           clock_source_select_reg};

    // Register writes; start-up flag is hardware owned
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            tune_reg <= osc_ctl_pkg::OSC_TUNING_RESET[osc_ctl_pkg::TUNE_W-1:0];
            pll_enable_bit_reg <= 1'b0;
            low_freq_source_select_reg <= 1'b0;
            clock_source_select_reg <= osc_ctl_pkg::CSS_RESET;
            low_freq_option_reg <= 1'b0;
            idle_on_sleep_enable_reg <= 1'b0;
        end else if (wr_tuning) begin
            tune_reg <=
                reg_wdata[osc_ctl_pkg::TUNE_LSB +: osc_ctl_pkg::TUNE_W];
            pll_enable_bit_reg <= reg_wdata[osc_ctl_pkg::PLL_EN_BIT];
            low_freq_source_select_reg <= reg_wdata[osc_ctl_pkg::LF_SRC_BIT];
        end else if (wr_control) begin
            clock_source_select_reg <= reg_wdata[osc_ctl_pkg::CSS_LSB +: 2];
            low_freq_option_reg <= reg_wdata[osc_ctl_pkg::LOW_FREQ_BIT];
            idle_on_sleep_enable_reg <= reg_wdata[osc_ctl_pkg::IDLE_BIT];
        end
    end

    // Read data stands one cycle after the read strobe
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rdata_reg <= '0;
        end else begin
            rdata_reg <= rd_tuning ? tuning_view :
                         rd_control ? control_view : '0;
        end
    end
    assign reg_rdata = rdata_reg;

    // new tuning applies after the settle time
    settle_timer #(.W(TW)) fast_settle (
        .clk(clk),
        .resetn(resetn),
        .start(wr_tuning),
        .cancel(1'b0),
        .count(TW'(FAST_SETTLE_CYCLES)),
        .busy(),
        .done(fast_settle_done)
    );

    // shift runs in background, nothing reports it
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            tune_applied_reg <=
                osc_ctl_pkg::OSC_TUNING_RESET[osc_ctl_pkg::TUNE_W-1:0];
        end else if (fast_settle_done) begin
            tune_applied_reg <= tune_reg;
        end
    end

    // signed tune times one fixed step
    assign tune_sx = {{(AW - osc_ctl_pkg::TUNE_W){tune_applied_reg[
                      osc_ctl_pkg::TUNE_W-1]}}, tune_applied_reg};
    // zero tune gives nominal 8 MHz
    assign fast_inc = AW'(osc_ctl_pkg::FAST_INC_NOM +
                          AW'(tune_sx * osc_ctl_pkg::FAST_INC_STEP));

    // Fast internal oscillator runs whenever the block is out of reset
    assign fast_if.inc = fast_inc;
    assign fast_if.run = 1'b1;
    osc_tick_gen #(.ACC_W(AW)) fast_internal_osc (
        .clk(clk),
        .resetn(resetn),
        .osc(fast_if)
    );

    // slow rate is fixed, tuning never reaches it
    // no retune, so slow rate is settled at once
    assign slow_if.inc = osc_ctl_pkg::SLOW_INC;
    // kept alive for watchdog or clock monitor
    assign slow_if.run = watchdog_enable || clock_monitor_enable ||
                         (cur_src_reg == osc_ctl_pkg::SRC_SLOW) ||
                         (target_src == osc_ctl_pkg::SRC_SLOW) ||
                         (pend_src_reg == osc_ctl_pkg::SRC_SLOW);
    assign slow_osc_running = slow_if.run;
    osc_tick_gen #(.ACC_W(AW)) slow_internal_osc (
        .clk(clk),
        .resetn(resetn),
        .osc(slow_if)
    );

    // Fast oscillator divided down to the 31 kHz option
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            low_div_reg <= '0;
            fast_low_tick_reg <= 1'b0;
        end else begin
            fast_low_tick_reg <= fast_if.tick && (&low_div_reg);
            if (fast_if.tick) begin
                low_div_reg <= low_div_reg + 1'b1;
            end
        end
    end

    // PLL only powers in a PLL oscillator mode
    assign internal_mode =
        (clock_source_select_reg == osc_ctl_pkg::CSS_INTERNAL);
    assign pll_on = pll_mode_config && pll_enable_bit_reg && !internal_mode;
    assign pll_power_on = pll_on;
    assign pll_rise = pll_on && !pll_on_d_reg;

    // lock wait before the PLL may clock the device
    settle_timer #(.W(TW)) pll_lock_timer (
        .clk(clk),
        .resetn(resetn),
        .start(pll_rise),
        .cancel(!pll_on),
        .count(TW'(PLL_LOCK_CYCLES)),
        .busy(),
        .done(pll_lock_done)
    );

    // Lock state follows the PLL power
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            pll_on_d_reg <= 1'b0;
            pll_locked_reg <= 1'b0;
        end else begin
            pll_on_d_reg <= pll_on;
            if (!pll_on) begin
                pll_locked_reg <= 1'b0;
            end else if (pll_lock_done) begin
                pll_locked_reg <= 1'b1;
            end
        end
    end

    // source bit set picks divided fast osc, clear picks 31 kHz oscillator
    assign base_internal = !low_freq_option_reg ? osc_ctl_pkg::SRC_FAST :
                           low_freq_source_select_reg ?
                           osc_ctl_pkg::SRC_FAST_LOW : osc_ctl_pkg::SRC_SLOW;

    // fast oscillator holds until primary ready
    assign target_src = internal_mode ? base_internal :
                        !primary_osc_ready ? osc_ctl_pkg::SRC_FAST :
                        pll_locked_reg ? osc_ctl_pkg::SRC_PLL :
                        osc_ctl_pkg::SRC_PRIMARY;

    // Tick of the running and of the pending source
    assign cur_tick =
        (cur_src_reg == osc_ctl_pkg::SRC_PRIMARY) ? primary_clk_tick :
        (cur_src_reg == osc_ctl_pkg::SRC_FAST) ? fast_if.tick :
        (cur_src_reg == osc_ctl_pkg::SRC_FAST_LOW) ? fast_low_tick_reg :
        (cur_src_reg == osc_ctl_pkg::SRC_SLOW) ? slow_if.tick : 1'b1;
    assign pend_tick =
        (pend_src_reg == osc_ctl_pkg::SRC_PRIMARY) ? primary_clk_tick :
        (pend_src_reg == osc_ctl_pkg::SRC_FAST) ? fast_if.tick :
        (pend_src_reg == osc_ctl_pkg::SRC_FAST_LOW) ? fast_low_tick_reg :
        (pend_src_reg == osc_ctl_pkg::SRC_SLOW) ? slow_if.tick : 1'b1;

    assign commit = (sw_state_reg == SW_ALIGN) && pend_tick;

    // old tick finishes, then wait for new tick
    always_comb begin
        sw_state_next = sw_state_reg;
        unique case (sw_state_reg)
            SW_RUN: begin
                if (target_src != cur_src_reg) begin
                    sw_state_next = SW_DRAIN;
                end
            end
            SW_DRAIN: begin
                if (cur_tick) begin
                    sw_state_next = SW_ALIGN;
                end
            end
            SW_ALIGN: begin
                if (pend_tick) begin
                    sw_state_next = SW_RUN;
                end
            end
        endcase
    end

    // Selector state; pending source latched when a switch starts
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            sw_state_reg <= SW_RUN;
            cur_src_reg <= osc_ctl_pkg::SRC_FAST;
            pend_src_reg <= osc_ctl_pkg::SRC_FAST;
        end else begin
            sw_state_reg <= sw_state_next;
            if (sw_state_reg == SW_RUN && target_src != cur_src_reg) begin
                pend_src_reg <= target_src;
            end
            if (commit) begin
                cur_src_reg <= pend_src_reg;
            end
        end
    end

    // one enable clocks CPU and peripherals
    assign device_clk_en = (sw_state_reg != SW_ALIGN) && cur_tick;
    assign active_source = cur_src_reg;

    // Primary oscillator power and start-up flag
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            primary_en_reg <= 1'b1;
            startup_complete_flag_reg <= 1'b0;
        end else if (!internal_mode) begin
            // primary starts while fast osc clocks
            primary_en_reg <= 1'b1;
            if (commit && (pend_src_reg == osc_ctl_pkg::SRC_PRIMARY ||
                           pend_src_reg == osc_ctl_pkg::SRC_PLL)) begin
                startup_complete_flag_reg <= 1'b1;
            end
        end else if ((commit && pend_src_reg == base_internal) ||
                     (sw_state_reg == SW_RUN &&
                      cur_src_reg == base_internal)) begin
            primary_en_reg <= 1'b0;
            startup_complete_flag_reg <= 1'b0;
        end
    end
    // switching never writes idle or select bits
    assign primary_osc_enable = primary_en_reg;

endmodule // osc_clock_ctl

`default_nettype wire

// [logic/osc_tick_gen.sv]
/*
 * Oscillator model: a phase accumulator emitting one-cycle tick pulses
 * at inc / 2**ACC_W of the system clock rate.
 * Assumes inc and run come from the system clock domain.
 */
`timescale 1ns/10ps
`default_nettype none

module osc_tick_gen #(
    parameter int ACC_W = 24
) (
    input wire logic clk,
    input wire logic resetn,
    tick_if.gen osc
);

    logic [ACC_W-1:0] acc_reg;
    logic tick_reg;
    logic [ACC_W:0] sum;

    // Carry out of the accumulator is the tick
    assign sum = {1'b0, acc_reg} + {1'b0, osc.inc};
    assign osc.tick = tick_reg;

    // Stopped oscillator holds phase at zero
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            acc_reg <= '0;
            tick_reg <= 1'b0;
        end else if (!osc.run) begin
            acc_reg <= '0;
            tick_reg <= 1'b0;
        end else begin
            acc_reg <= sum[ACC_W-1:0];
            tick_reg <= sum[ACC_W];
        end
    end

endmodule // osc_tick_gen

`default_nettype wire

// [logic/settle_timer.sv]
/*
 * Restartable down counter: start loads count, done pulses once when
 * the count has run out.
 * Assumes count is at least one.
 */
`timescale 1ns/10ps
`default_nettype none

module settle_timer #(
    parameter int W = 17
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic start,
    input wire logic cancel,
    input wire logic [W-1:0] count,
    output logic busy,
    output logic done
);

    logic [W-1:0] cnt_reg;
    logic busy_reg;
    logic done_reg;

    assign busy = busy_reg;
    assign done = done_reg;

    // Start wins over cancel so a fresh request is never lost
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            cnt_reg <= '0;
            busy_reg <= 1'b0;
            done_reg <= 1'b0;
        end else begin
            done_reg <= 1'b0;
            if (start) begin
                cnt_reg <= count;
                busy_reg <= 1'b1;
            end else if (cancel) begin
                busy_reg <= 1'b0;
            end else if (busy_reg) begin
                cnt_reg <= cnt_reg - 1'b1;
                if (cnt_reg == W'(1)) begin
                    busy_reg <= 1'b0;
                    done_reg <= 1'b1;
                end
            end
        end
    end

endmodule // settle_timer

`default_nettype wire
